// *** rtl/scg_pkg.sv ***
// Constants shared by the secondary clock gating and system-error flag block.
// Assumes a single PCI clock domain; offsets are configuration-space byte addresses.
package scg_pkg;

  // ==========================================================================
  // Register placement
  // ==========================================================================
  localparam logic [7:0] SCG_CFG_OFFSET = 8'h68; // Shared dword of both registers

  // ==========================================================================
  // Clock gating field layout
  // ==========================================================================
  localparam int SCG_GATE_W = 14;          // Writable gating bits 13:0
  localparam int SCG_SLOT_N = 4;           // Slot clocks with 2-bit fields
  localparam int SCG_DEV_N = 6;            // Device clocks plus self clock, 1 bit each
  localparam int SCG_CLK_N = 10;           // Gated secondary clock outputs
  localparam int SCG_DEV_LSB = 8;          // First 1-bit field
  localparam int SCG_SELF_BIT = 13;        // Self clock gating bit
  localparam int SCG_RSVD_LSB = 14;        // Reserved bits 15:14
  localparam logic [1:0] SCG_SLOT_STOP = 2'h3;
  localparam logic [13:0] SCG_GATE_RESET = 14'h0000;
  localparam logic [1:0] SCG_RSVD_VALUE = 2'h3;

  // ==========================================================================
  // System-error cause flags
  // ==========================================================================
  localparam int SCG_STATUS_LSB = 16;
  localparam int SCG_STATUS_W = 8;
  localparam logic [7:0] SCG_STATUS_RESET = 8'h00;
  localparam logic [7:0] SCG_MASKABLE = 8'h7c; // Causes with a mask bit: 18..22

endpackage

// *** rtl/scg_preload_if.sv ***
// Carries the serially preloaded gating value from the loader to the register bank.
// Assumes both ends sit on the same clock; load is a one-cycle pulse.
`timescale 1ns/100ps
interface scg_preload_if;
  logic load;
  logic [scg_pkg::SCG_GATE_W-1:0] bits;

  // ==========================================================================
  // Directions
  // ==========================================================================
  modport src (output load, output bits);
  modport dst (input load, input bits);
endinterface

// *** rtl/scg_clk_gate.sv ***
// Divides the PCI clock by two and gates each secondary clock output.
// Assumes stop_in comes from flops on clk_in; outputs are flops.
`timescale 1ns/100ps
module scg_clk_gate #(
  parameter int N = 10
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Gating requests, 1 = stop and hold high
  input wire logic [N-1:0] stop_in,
  // Gated clocks
  output logic [N-1:0] clk_out
);

  typedef struct packed {
    logic phase;
    logic [N-1:0] run;
    logic [N-1:0] out;
  } scg_gate_s;

  scg_gate_s cur_ff;
  scg_gate_s nxt_ff;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Run flags move only while the common phase is high, so every output is
  // high at the switch: a stop holds it high, a start begins with a full low
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.phase = ~cur_ff.phase;
    if (cur_ff.phase) begin
      nxt_ff.run = ~stop_in; // [RQ16]
    end
    nxt_ff.out = ~nxt_ff.run | {N{nxt_ff.phase}};
  end

  // Registered state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '{phase: 1'b1, run: {N{1'b1}}, out: {N{1'b1}}};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign clk_out = cur_ff.out;

endmodule

// *** rtl/scg_serial_preload.sv ***
// Shifts in the gating preset while secondary reset is held.
// Assumes reset, shift strobe and data are pins from outside the clock domain.
`timescale 1ns/100ps
module scg_serial_preload #(
  parameter int W = 14
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins
  input wire logic sec_rst_n_in,
  input wire logic ser_shift_in,
  input wire logic ser_data_in,
  // Preload towards the register bank
  scg_preload_if.src pre
);

  localparam int CW = $clog2(W + 1);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] sck_sync;
    logic [1:0] dat_sync;
    logic in_rst;
    logic [W-1:0] shreg;
    logic [CW-1:0] cnt;
    logic load;
    logic [W-1:0] bits;
  } scg_pre_s;

  scg_pre_s cur_ff;
  scg_pre_s nxt_ff;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Bits arrive MSB first on rising shift strobes; a short stream loads nothing
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.rst_sync = {cur_ff.rst_sync[0], sec_rst_n_in};
    nxt_ff.sck_sync = {cur_ff.sck_sync[1:0], ser_shift_in};
    nxt_ff.dat_sync = {cur_ff.dat_sync[0], ser_data_in};
    nxt_ff.in_rst = ~cur_ff.rst_sync[1];
    nxt_ff.load = 1'b0;
    if (cur_ff.in_rst) begin
      if (cur_ff.sck_sync[1] && !cur_ff.sck_sync[2] && cur_ff.cnt != CW'(W)) begin
        nxt_ff.shreg = {cur_ff.shreg[W-2:0], cur_ff.dat_sync[1]};
        nxt_ff.cnt = cur_ff.cnt + CW'(1);
      end
      if (!nxt_ff.in_rst && cur_ff.cnt == CW'(W)) begin
        nxt_ff.load = 1'b1; // [RQ4]
        nxt_ff.bits = cur_ff.shreg;
      end
    end else begin
      nxt_ff.cnt = '0;
    end
  end

  // Registered state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '{rst_sync: 2'h3, sck_sync: 3'h0, dat_sync: 2'h0, in_rst: 1'b0,
                  shreg: '0, cnt: '0, load: 1'b0, bits: '0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign pre.load = cur_ff.load;
  assign pre.bits = cur_ff.bits;

endmodule

// *** rtl/scg_clock_serr_regs.sv ***
// Secondary clock gating register and system-error cause flags at one config dword.
// Assumes configuration strobes and error events come from logic on clk_in.
// Notes on behaviour
// (RQ1) Slot clocks 0..3 run for field codes 00, 01, 10 and stop high for 11, fields reset to 00.
// (RQ2) Device clocks 4..8 run when their bit at 8..12 is 0 and stop high when it is 1, reset 0.
// (RQ3) Bit 13 gates the clock feeding the bridge's own secondary clock input, 1 stops it high.
// (RQ4) On secondary reset the gating bits are preset from a serially shifted stream.
// (RQ5) Bits 15:14 are read-only, ignore writes and always read as 1.
// (RQ6) Flag 16 records a system error caused by an address parity error on either bus.
// (RQ7) Flag 17 records a system error caused by posted write data parity error on the target bus.
// (RQ8) Flag 18 records a system error caused by posted memory write non-delivery after the retry limit.
// (RQ9) Flag 19 records a system error caused by a target abort on posted memory write.
// (RQ10) Flag 20 records a system error caused by a master abort on posted memory write.
// (RQ11) Flag 21 records a system error caused by delayed write non-delivery after the retry limit.
// (RQ12) Flag 22 records a system error caused by a delayed read getting no data within the retry limit.
// (RQ13) Flag 23 records a system error caused by a master not repeating a delayed transaction in time.
// (RQ14) A maskable cause raises the system error only with its mask bit 0 and the enable bit set.
// (RQ15) Each flag resets to 0, stays set, clears on a written 1 and ignores a written 0.
// (RQ16) Gating changes take effect only while the output is high, so no short pulse leaves.
`timescale 1ns/100ps
module scg_clock_serr_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Configuration access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rack_out,
  // Secondary reset and serial preset pins
  input wire logic sec_rst_n_in,
  input wire logic ser_shift_in,
  input wire logic ser_data_in,
  // System-error causes and gating
  input wire logic [7:0] serr_event_in,
  input wire logic [7:0] serr_mask_in,
  input wire logic serr_enable_in,
  // Open-drain system-error pin
  output logic primary_system_error_n_out,
  output logic primary_system_error_oe_out,
  // Gated secondary clocks
  output logic [scg_pkg::SCG_CLK_N-1:0] secondary_clock_output_out
);

  typedef struct packed {
    logic [scg_pkg::SCG_GATE_W-1:0] gate;
    logic [scg_pkg::SCG_STATUS_W-1:0] status;
    logic [31:0] rdata;
    logic rack;
    logic serr_n;
    logic serr_oe;
  } scg_regs_s;

  scg_regs_s cur_ff;
  scg_regs_s nxt_ff;

  logic [scg_pkg::SCG_CLK_N-1:0] stop;
  logic [7:0] fire;
  logic [7:0] clr;
  logic hit_wr;
  logic hit_rd;

  scg_preload_if pre_if ();

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Dword match; low address bits select bytes through the enables
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = addr[7:2] == scg_pkg::SCG_CFG_OFFSET[7:2];
  endfunction

  // Read image of the dword
  function automatic logic [31:0] read_image(input logic [13:0] gate, input logic [7:0] status);
    read_image = {8'h00, status, scg_pkg::SCG_RSVD_VALUE, gate}; // [RQ5]
  endfunction

  // ==========================================================================
  // Serial preset loader
  // ==========================================================================
  scg_serial_preload #(
    .W(scg_pkg::SCG_GATE_W)
  ) u_preload (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .sec_rst_n_in(sec_rst_n_in),
    .ser_shift_in(ser_shift_in),
    .ser_data_in(ser_data_in),
    .pre(pre_if.src)
  );

  // ==========================================================================
  // Gating decode
  // ==========================================================================
  // Slot fields stop only on code 11; the other three codes all run
  always_comb begin
    stop = '0;
    for (int i = 0; i < scg_pkg::SCG_SLOT_N; i++) begin
      stop[i] = cur_ff.gate[2*i +: 2] == scg_pkg::SCG_SLOT_STOP; // [RQ1]
    end
    for (int k = 0; k < scg_pkg::SCG_DEV_N; k++) begin
      stop[scg_pkg::SCG_SLOT_N + k] = cur_ff.gate[scg_pkg::SCG_DEV_LSB + k]; // [RQ2] [RQ3]
    end
  end

  // Clock dividers and glitch-free gates
  scg_clk_gate #(
    .N(scg_pkg::SCG_CLK_N)
  ) u_clk_gate (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .stop_in(stop),
    .clk_out(secondary_clock_output_out)
  );

  // ==========================================================================
  // Register next state
  // ==========================================================================
  // Config decode, error flags and read answer
  always_comb begin
    nxt_ff = cur_ff;
    hit_wr = cfg_wr_in && addr_hit(cfg_addr_in);
    hit_rd = cfg_rd_in && addr_hit(cfg_addr_in);
    // Byte lanes 0 and 1 hold gating; 15:14 never take a write
    if (hit_wr && cfg_be_in[0]) begin
      nxt_ff.gate[7:0] = cfg_wdata_in[7:0]; // [RQ1]
    end
    if (hit_wr && cfg_be_in[1]) begin
      nxt_ff.gate[13:8] = cfg_wdata_in[13:8]; // [RQ2] [RQ3] [RQ5]
    end
    // A preset after secondary reset overrides a write in the same cycle
    if (pre_if.load) begin
      nxt_ff.gate = pre_if.bits; // [RQ4]
    end
    // Parity causes carry no mask bit, only the common enable
    fire = serr_event_in & ~(serr_mask_in & scg_pkg::SCG_MASKABLE) & {8{serr_enable_in}}; // [RQ14]
    clr = (hit_wr && cfg_be_in[2]) ? cfg_wdata_in[23:16] : 8'h00;
    // Set wins over clear so an event in the clearing cycle survives
    nxt_ff.status = (cur_ff.status & ~clr) | fire; // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ12] [RQ13] [RQ15]
    nxt_ff.serr_n = ~|fire;
    nxt_ff.serr_oe = |fire; // [RQ14]
    nxt_ff.rack = hit_rd;
    nxt_ff.rdata = hit_rd ? read_image(cur_ff.gate, cur_ff.status) : 32'h00000000;
  end

  // Registered state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '{gate: scg_pkg::SCG_GATE_RESET, status: scg_pkg::SCG_STATUS_RESET,
                  rdata: 32'h00000000, rack: 1'b0, serr_n: 1'b1, serr_oe: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Pin is only ever pulled low, so data follows the enable
  assign cfg_rdata_out = cur_ff.rdata;
  assign cfg_rack_out = cur_ff.rack;
  assign primary_system_error_n_out = cur_ff.serr_n;
  assign primary_system_error_oe_out = cur_ff.serr_oe;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Stop request held long enough for the half-period switch point
  sequence s_slot0_stopped;
    (cur_ff.gate[1:0] == 2'h3)[*4];
  endsequence

  sequence s_dev4_stopped;
    cur_ff.gate[8][*4];
  endsequence

  sequence s_self_stopped;
    cur_ff.gate[13][*4];
  endsequence

  sequence s_slot0_low;
    $fell(secondary_clock_output_out[0]);
  endsequence

  a_rsvd_reads_one: assert property (cfg_rack_out |-> cfg_rdata_out[15:14] == 2'h3) // [RQ5]
    else $error("reserved bits did not read as ones");

  a_slot_stop_high: assert property (s_slot0_stopped |-> secondary_clock_output_out[0]) // [RQ1]
    else $error("stopped slot clock not held high");

  a_slot_code_runs: assert property ((cur_ff.gate[1:0] == 2'h2)[*4] |-> // [RQ1]
      secondary_clock_output_out[0] != $past(secondary_clock_output_out[0]))
    else $error("slot clock not toggling for code 10");

  a_dev_stop_high: assert property (s_dev4_stopped |-> secondary_clock_output_out[4]) // [RQ2]
    else $error("stopped device clock not held high");

  a_self_stop_high: assert property (s_self_stopped |-> secondary_clock_output_out[9]) // [RQ3]
    else $error("stopped self clock not held high");

  a_preload_takes: assert property (pre_if.load |=> cur_ff.gate == $past(pre_if.bits)) // [RQ4]
    else $error("preset value not loaded into gating bits");

  a_flag_sets: assert property (fire != 8'h00 |=> // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ12] [RQ13]
      (cur_ff.status & $past(fire)) == $past(fire))
    else $error("cause flag not set after system error");

  a_serr_gated: assert property (primary_system_error_oe_out |-> // [RQ14]
      $past(serr_enable_in) && ($past(serr_event_in & ~(serr_mask_in & scg_pkg::SCG_MASKABLE)) != 8'h00))
    else $error("system error driven without an enabled cause");

  a_serr_pulse: assert property ((serr_enable_in && serr_event_in[0]) |=> // [RQ14]
      primary_system_error_oe_out && !primary_system_error_n_out)
    else $error("enabled cause did not drive system error");

  a_w1c_clear: assert property ((hit_wr && cfg_be_in[2] && serr_event_in == 8'h00) |=> // [RQ15]
      cur_ff.status == ($past(cur_ff.status) & ~$past(cfg_wdata_in[23:16])))
    else $error("flag clear did not follow written ones");

  a_flag_sticky: assert property ((!hit_wr && cur_ff.status[7]) |=> cur_ff.status[7]) // [RQ15]
    else $error("cause flag dropped without a clear");

  a_no_runt_low: assert property (s_slot0_low |=> $rose(secondary_clock_output_out[0])) // [RQ16]
    else $error("slot clock low phase not one full cycle");

  a_no_runt_high: assert property ($rose(secondary_clock_output_out[9]) |=> // [RQ16]
      secondary_clock_output_out[9] || $past(stop[9]) == 1'b0)
    else $error("self clock high phase shortened");

  // ==========================================================================
  // Register bus checks
  // ==========================================================================
  // Read steps: a strobe on the dword, then its answer one cycle later
  sequence s_read_taken;
    cfg_rd_in && cfg_addr_in[7:2] == scg_pkg::SCG_CFG_OFFSET[7:2];
  endsequence

  sequence s_read_answer;
    cfg_rack_out && cfg_rdata_out[31:24] == 8'h00;
  endsequence

  a_read_answers: assert property (s_read_taken |=> s_read_answer) // [RQ5]
    else $error("dword read not answered in the next cycle");

  a_stray_answer: assert property (cfg_rack_out |-> $past(hit_rd)) // [RQ5]
    else $error("read answer without a dword read");

  // Zero data outside an answer keeps an idle bus from passing for a read
  a_idle_data_zero: assert property (!cfg_rack_out |-> cfg_rdata_out == 32'h00000000) // [RQ5]
    else $error("read data not zero outside an answer");

  a_read_image: assert property (s_read_taken |=> // [RQ5] [RQ15]
      cfg_rdata_out == {8'h00, $past(cur_ff.status), scg_pkg::SCG_RSVD_VALUE, $past(cur_ff.gate)})
    else $error("read image does not match gating and flags");

  // Write steps: a strobe on the dword with a lane set and no preset pending
  sequence s_gate_lo_write;
    hit_wr && cfg_be_in[0] && !pre_if.load;
  endsequence

  sequence s_gate_hi_write;
    hit_wr && cfg_be_in[1] && !pre_if.load;
  endsequence

  a_gate_lo_write: assert property (s_gate_lo_write |=> // [RQ1]
      cur_ff.gate[7:0] == $past(cfg_wdata_in[7:0]))
    else $error("slot gating byte did not take the write");

  a_gate_hi_write: assert property (s_gate_hi_write |=> // [RQ2] [RQ3]
      cur_ff.gate[13:8] == $past(cfg_wdata_in[13:8]))
    else $error("device gating bits did not take the write");

  a_gate_holds: assert property ((!hit_wr && !pre_if.load) |=> $stable(cur_ff.gate)) // [RQ1] [RQ2] [RQ4]
    else $error("gating bits changed without a write or preset");

  // ==========================================================================
  // Clock and pin checks
  // ==========================================================================
  // Four cycles give the gate time to pass its next high phase
  a_dev_runs: assert property ((!cur_ff.gate[8])[*4] |-> // [RQ2]
      secondary_clock_output_out[4] != $past(secondary_clock_output_out[4]))
    else $error("enabled device clock not toggling");

  a_self_runs: assert property ((!cur_ff.gate[13])[*4] |-> // [RQ3]
      secondary_clock_output_out[9] != $past(secondary_clock_output_out[9]))
    else $error("enabled self clock not toggling");

  // Open-drain pin: data low exactly while the enable drives it
  a_pin_follows_oe: assert property ( // [RQ14]
      primary_system_error_n_out == !primary_system_error_oe_out)
    else $error("system error data and enable disagree");

  a_disabled_quiet: assert property (!serr_enable_in |=> !primary_system_error_oe_out) // [RQ14]
    else $error("system error driven while disabled");

  sequence s_no_live_cause;
    (serr_event_in & ~(serr_mask_in & scg_pkg::SCG_MASKABLE)) == 8'h00;
  endsequence

  a_masked_quiet: assert property (s_no_live_cause |=> !primary_system_error_oe_out) // [RQ14]
    else $error("masked cause drove system error");

  // A flag may only rise on a cause and only fall on a written one
  a_flag_needs_cause: assert property ( // [RQ15]
      (cur_ff.status & ~$past(cur_ff.status) & ~$past(fire)) == 8'h00)
    else $error("cause flag set without a cause");

  a_zero_keeps: assert property ((hit_wr && cfg_be_in[2]) |=> // [RQ15]
      ($past(cur_ff.status) & ~$past(cfg_wdata_in[23:16]) & ~cur_ff.status) == 8'h00)
    else $error("flag cleared by a written zero");

endmodule

// *** test/scg_cfg_master.sv ***
// Configuration master model for the clock gating and error flag bank.
// Assumes one clock; requests launch by non-blocking assignment at an edge.
`timescale 1ns/100ps
module scg_cfg_master (
  // Clock
  input wire logic clk_in,
  // Strobes towards the bank
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  output logic [7:0] cfg_addr_out,
  output logic [3:0] cfg_be_out,
  output logic [31:0] cfg_wdata_out,
  // Read answer
  input wire logic [31:0] cfg_rdata_in,
  input wire logic cfg_rack_in
);
  // ==========================================================================
  // Idle bus
  // ==========================================================================
  // Idle address never hits the dword
  initial begin
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_be_out = 4'h0;
    cfg_wdata_out = 32'h0;
  end

  // Released lines show a garbled copy, so stale data cannot pass for good
  task automatic idle();
    cfg_wr_out <= 1'b0;
    cfg_rd_out <= 1'b0;
    cfg_addr_out <= ~cfg_addr_out;
    cfg_be_out <= ~cfg_be_out;
    cfg_wdata_out <= ~cfg_wdata_out;
  endtask

  // ==========================================================================
  // Transfers
  // ==========================================================================
  // One-cycle write strobe, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_in);
    cfg_wr_out <= 1'b1;
    cfg_addr_out <= a;
    cfg_be_out <= b;
    cfg_wdata_out <= d;
    @(posedge clk_in);
    idle();
  endtask

  // Answer stands from the taking edge on, read 1 ns after it
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk_in);
    cfg_rd_out <= 1'b1;
    cfg_addr_out <= a;
    @(posedge clk_in);
    idle();
    #1;
    ok = cfg_rack_in;
    d = cfg_rdata_in;
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the clock gating and error flag bank.
// Assumes the master model and the bank share one 50 MHz clock.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sec_n = 1'b1;
  logic shf = 1'b0;
  logic sdat = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] msk = 8'h00;
  logic en = 1'b0;
  logic wr, rd, rack, ser_n, ser_oe, ph;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdt;
  logic [9:0] clko;
  int error_cnt = 0;
  int checks = 0;

  // ==========================================================================
  // Clock, parts
  // ==========================================================================
  always #10 clk = ~clk;

  scg_cfg_master i_mst (.clk_in(clk), .cfg_wr_out(wr), .cfg_rd_out(rd), .cfg_addr_out(addr),
    .cfg_be_out(be), .cfg_wdata_out(wd), .cfg_rdata_in(rdt), .cfg_rack_in(rack));

  scg_clock_serr_regs i_dut (.clk_in(clk), .rstn_in(rst_n), .cfg_wr_in(wr), .cfg_rd_in(rd),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdt),
    .cfg_rack_out(rack), .sec_rst_n_in(sec_n), .ser_shift_in(shf), .ser_data_in(sdat),
    .serr_event_in(ev), .serr_mask_in(msk), .serr_enable_in(en),
    .primary_system_error_n_out(ser_n), .primary_system_error_oe_out(ser_oe),
    .secondary_clock_output_out(clko));

  // Reference phase of the divided clock; a low output off this phase is a cut pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 1'b1;
    end else begin
      ph <= ~ph;
    end
  end
  always @(negedge clk) begin
    if (rst_n && ph && clko !== 10'h3ff) begin
      error_cnt++;
      $display("unexpected at %0t: clock low out of phase %h", $time, clko);
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Read the dword and compare, answer flag included
  task automatic rdc(input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    i_mst.rd(8'h68, d, ok);
    cmp({31'h0, ok}, 32'h1);
    cmp(d, exp);
  endtask

  // Running outputs toggle each cycle, stopped ones stay high
  task automatic clkc(input logic [9:0] s);
    logic [9:0] a;
    repeat (3) @(posedge clk);
    #1;
    a = clko;
    @(posedge clk);
    #1;
    cmp({22'h0, ((a ^ clko) & ~s) | (a & clko & s)}, 32'h3ff);
  endtask

  // One-cycle cause pulse, pin checked in the following cycle
  task automatic pulse(input logic [7:0] e, input logic fire);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
    #1;
    cmp({30'h0, ser_oe, ser_n}, fire ? 32'h2 : 32'h1);
  endtask

  // Serial preset bits, first one lands in gate bit 13
  task automatic shift(input logic [13:0] v, input int n);
    for (int i = 13; i > 13 - n; i--) begin
      sdat <= v[i];
      repeat (4) @(posedge clk);
      shf <= 1'b1;
      repeat (4) @(posedge clk);
      shf <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic [31:0] d;
    logic ok;
    repeat (3) @(posedge clk);
    cmp({22'h0, clko}, 32'h3ff);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(32'h0000c000);
    clkc(10'h000);
    // Every slot code on all four fields at once
    for (int c = 0; c < 4; c++) begin
      i_mst.wr(8'h68, 4'h1, {24'h0, {4{c[1:0]}}});
      rdc({16'h0, 8'hc0, {4{c[1:0]}}});
      clkc(c == 3 ? 10'h00f : 10'h000);
    end
    i_mst.wr(8'h68, 4'h3, 32'h00003f00);
    rdc(32'h0000ff00);
    clkc(10'h3f0);
    i_mst.wr(8'h68, 4'hf, 32'hffffffff);
    rdc(32'h0000ffff);
    i_mst.wr(8'h68, 4'h3, 32'h00000000);
    rdc(32'h0000c000);
    clkc(10'h000);
    // Each cause sets its own flag; 0 keeps it, 1 clears it
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 1'b1);
      rdc(32'h0000c000 | (32'h1 << (16 + i)));
      i_mst.wr(8'h68, 4'h4, 32'h0);
      rdc(32'h0000c000 | (32'h1 << (16 + i)));
      i_mst.wr(8'h68, 4'h4, 32'h1 << (16 + i));
      rdc(32'h0000c000);
    end
    // Masked causes stay silent; unmaskable ones still fire
    @(posedge clk);
    msk <= 8'hff;
    pulse(8'h7c, 1'b0);
    pulse(8'h83, 1'b1);
    rdc(32'h0083c000);
    i_mst.wr(8'h68, 4'h4, 32'h00ff0000);
    msk <= 8'h00;
    en <= 1'b0;
    pulse(8'hff, 1'b0);
    rdc(32'h0000c000);
    // Other addresses neither answer nor change anything
    i_mst.rd(8'h6c, d, ok);
    cmp({31'h0, ok}, 32'h0);
    cmp(d, 32'h0);
    i_mst.wr(8'h64, 4'hf, 32'hffffffff);
    rdc(32'h0000c000);
    // Serial preset under secondary reset, then a short stream that must not load
    @(posedge clk);
    sec_n <= 1'b0;
    shift(14'h2a5b, 14);
    sec_n <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(32'h0000ea5b);
    clkc(10'h2a1);
    @(posedge clk);
    sec_n <= 1'b0;
    shift(14'h0000, 5);
    sec_n <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(32'h0000ea5b);
    wrap_up();
  end

  // Tests take well under 3000 cycles
  initial begin
    #200000;
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
